// [tb_two_wire_eeprom_slave_write.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_two_wire_eeprom_slave_write;
   import tee_pkg::*;
   localparam logic [31:0] WCYC = 32'h000003E8;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, q;
   logic        pready, pslverr, scl, sda_low, sda_out, sda_oe_n, sda, e;
   logic        prog_start, prog_id, standby, wp = 1'b0, lock = 1'b0;
   logic [2:0]  strap = 3'h5;
   logic [8:0]  prog_page;
   int          errors = 0;
   int          samples_checked = 0;
   int          nprog = 0;
   assign sda = !sda_low && (sda_oe_n || sda_out);
   always #4 pclk = ~pclk;
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   end
   always @(posedge pclk) begin
      if (prog_start === 1'b1) nprog <= nprog + 1;
   end
   tee_slave #(.WRITE_CYCLES(WCYC)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
      .write_protect_in(wp), .chip_select_strap_bit0(strap[0]),
      .chip_select_strap_bit1(strap[1]), .chip_select_strap_bit2(strap[2]),
      .id_page_locked_in(lock), .prog_start, .prog_id, .prog_page, .standby);
   tee_i2c_master i_mst (.scl, .sda_low, .sda);
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         errors++;
         test_done();
      end
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk("prdata", exp, q);
   endtask : rdc
   task automatic snd(input logic [7:0] b, input logic exp);
      logic a;
      i_mst.put_byte(b, a);
      chk("ack", 32'(exp), 32'(a));
   endtask : snd
   task automatic settle(input int n);
      int k;
      for (k = 0; k < 3000; k++) begin
         @(posedge pclk);
         if (nprog == n && standby === 1'b1) break;
      end
      chk("programming count", n, nprog);
      if (k >= 3000) begin
         errors++;
         test_done();
      end
   endtask : settle
   logic [7:0] adr [4] = '{8'hA0, 8'hCA, 8'hAE, 8'hAB};
   logic       ack [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   initial begin
      repeat (8) @(posedge pclk);
      chk("standby", 1, 32'(standby));
      apb(1'b1, REG_CTRL, 32'h00001388);
      rdc(REG_CTRL, WCYC);
      apb(1'b1, REG_CTRL, 32'h00000190);
      apb(1'b0, 12'h010, 32'h00000000);
      chk("pslverr", 1, 32'(e));
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         i_mst.start();
         snd(adr[i], ack[i]);
         i_mst.stop();
      end
      settle(0);
      $display("test addressing done");
      i_mst.start();
      snd(8'hAA, 1'b1);
      snd(8'h01, 1'b1);
      snd(8'h7F, 1'b1);
      snd(8'h5A, 1'b1);
      rdc(12'h1FC, 32'h0000005A);
      i_mst.stop();
      i_mst.start();
      snd(8'hAA, 1'b0);
      i_mst.stop();
      settle(1);
      chk("page", 32'h5, 32'(prog_page));
      i_mst.start();
      snd(8'hAA, 1'b1);
      i_mst.stop();
      $display("test byte write done");
      i_mst.start();
      snd(8'hAA, 1'b1);
      snd(8'h00, 1'b1);
      snd(8'h7E, 1'b1);
      for (int i = 0; i < 66; i++) snd(i[7:0], 1'b1);
      rdc(12'h1F8, 32'h00000040);
      rdc(12'h1FC, 32'h00000041);
      rdc(12'h100, 32'h00000002);
      rdc(REG_VALID_LO, 32'hFFFFFFFF);
      i_mst.stop();
      settle(2);
      chk("page", 32'h1, 32'(prog_page));
      $display("test page write done");
      @(posedge pclk);
      wp <= 1'b1;
      i_mst.start();
      snd(8'hAA, 1'b1);
      snd(8'h00, 1'b1);
      snd(8'h10, 1'b1);
      snd(8'h77, 1'b1);
      rdc(REG_VALID_LO, 32'h00000000);
      i_mst.stop();
      settle(2);
      @(posedge pclk);
      wp <= 1'b0;
      i_mst.start();
      snd(8'hBA, 1'b1);
      snd(8'h03, 1'b1);
      snd(8'hC5, 1'b1);
      snd(8'h33, 1'b1);
      rdc(12'h114, 32'h00000033);
      i_mst.stop();
      settle(3);
      chk("id", 32'h1, 32'(prog_id));
      chk("page", 32'h0, 32'(prog_page));
      @(posedge pclk);
      lock <= 1'b1;
      i_mst.start();
      snd(8'hBA, 1'b1);
      snd(8'h00, 1'b1);
      snd(8'h05, 1'b1);
      snd(8'h44, 1'b0);
      rdc(REG_VALID_LO, 32'h00000000);
      i_mst.stop();
      settle(3);
      $display("test protection done");
      i_mst.start();
      snd(8'hAA, 1'b1);
      for (int i = 0; i < 3; i++) i_mst.bit_io(1'b0, e);
      i_mst.recover();
      snd(8'hAA, 1'b1);
      i_mst.stop();
      settle(3);
      $display("test bus reset done");
      test_done();
   end
endmodule : tb_two_wire_eeprom_slave_write
bind tee_slave tee_slave_assertions i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .scl_in, .sda_out, .sda_oe_n, .prog_start, .prog_id, .prog_page, .standby);
`default_nettype wire

// [tee_i2c_master.sv]
`timescale 1ns/10ps
`default_nettype none
module tee_i2c_master (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // low phase kept long so data edges stay clear of the input filter
   localparam int Q = 40;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic start;
      #Q sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
   endtask : start
   task automatic stop;
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
   endtask : stop
   task automatic bit_io(input logic b, output logic got);
      #Q sda_low = !b;
      #Q scl = 1'b1;
      #(Q/2) got = sda;
      #(Q/2) scl = 1'b0;
   endtask : bit_io
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic d;
      for (int i = 7; i >= 0; i--) bit_io(b[i], d);
      bit_io(1'b1, d);
      ack = !d;
   endtask : put_byte
   task automatic recover;
      logic d;
      d = 1'b0;
      for (int i = 0; i < 9 && !d; i++) bit_io(1'b1, d);
      start();
   endtask : recover
endmodule : tee_i2c_master
`default_nettype wire

// [tee_pkg.sv]
`default_nettype none
package tee_pkg;
   // timing of the self-timed write cycle
   localparam int unsigned CLK_KHZ          = 125000;
   localparam int unsigned T_WRITE_US       = 5000;
   localparam int unsigned WRITE_CYCLES_DEF = T_WRITE_US * CLK_KHZ / 1000;
   localparam int          CNT_W            = 20;
   localparam logic [CNT_W-1:0] CNT_ONE     = 20'h00001;

   // slave address byte
   localparam logic [3:0] TYPE_ARRAY = 4'hA;
   localparam logic [3:0] TYPE_ID    = 4'hB;
   localparam logic       DIR_READ   = 1'b1;

   // page and address layout
   localparam int         PAGE_BYTES = 64;
   localparam int         OFF_W      = 6;
   localparam int         PAGE_W     = 9;
   localparam int         HI_A10_BIT = 2;
   localparam logic [3:0] BITS_BYTE  = 4'h8;

   // byte position inside a transfer
   localparam logic [1:0] BYTE_DEV  = 2'h0;
   localparam logic [1:0] BYTE_HI   = 2'h1;
   localparam logic [1:0] BYTE_LO   = 2'h2;
   localparam logic [1:0] BYTE_DATA = 2'h3;

   // synchroniser lanes
   localparam int         IN_W     = 7;
   localparam int         IN_SCL   = 0;
   localparam int         IN_SDA   = 1;
   localparam int         IN_WP    = 2;
   localparam int         IN_LOCK  = 3;
   localparam int         IN_STRAP = 4;
   localparam logic [6:0] IN_RST   = 7'h03;

   // apb register map
   localparam int          PADDR_W      = 12;
   localparam logic [11:0] REG_CTRL     = 12'h000;
   localparam logic [11:0] REG_STATUS   = 12'h004;
   localparam logic [11:0] REG_VALID_LO = 12'h008;
   localparam logic [11:0] REG_VALID_HI = 12'h00C;
   localparam logic [3:0]  BUF_SEL      = 4'h1;

   // status fields
   localparam int ST_BUSY    = 0;
   localparam int ST_STANDBY = 1;
   localparam int ST_LOCKED  = 2;
   localparam int ST_WP      = 3;
   localparam int ST_PENDING = 4;
   localparam int ST_PAGE_LO = 16;

   typedef enum logic [1:0] {
      TEE_IDLE = 2'b00,
      TEE_RX   = 2'b01,
      TEE_ACK  = 2'b10
   } tee_state_e;
endpackage : tee_pkg
`default_nettype wire

// [tee_slave.sv]
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - start is sda falling while scl high
// - stop is sda rising while scl high
// - sda changes during scl high are framing
// - receiver acks by pulling sda low
// - start resets the bus machine anywhere
// - standby when idle and not programming
// - upper nibble must be a device type
// - next three bits match strap pins
// - last address bit selects read or write
// - matching address acked on ninth clock
// - byte write programs at following stop
// - no acknowledge while programming runs
// - each page data byte acked at once
// - only low six address bits increment
// - page overflow wraps and overwrites
// - whole page programmed in one cycle
// - address polling unacked while busy
// - write protect high blocks array writes
// - type 1011 selects identification page
// - id page needs bit ten zero, offset low six
// - locked id page data bytes not acked
module tee_slave #(
   parameter int unsigned WRITE_CYCLES = tee_pkg::WRITE_CYCLES_DEF
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [tee_pkg::PADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        scl_in,
   input  wire logic                        sda_in,
   output logic                             sda_out,
   output logic                             sda_oe_n,
   input  wire logic                        write_protect_in,
   input  wire logic                        chip_select_strap_bit0,
   input  wire logic                        chip_select_strap_bit1,
   input  wire logic                        chip_select_strap_bit2,
   input  wire logic                        id_page_locked_in,
   output logic                             prog_start,
   output logic                             prog_id,
   output logic      [tee_pkg::PAGE_W-1:0]  prog_page,
   output logic                             standby
);
   import tee_pkg::*;

   typedef struct packed {
      logic [IN_W-1:0]                   s1;
      logic [IN_W-1:0]                   s2;
      logic [IN_W-1:0]                   s3;
      logic [IN_W-1:0]                   flt;
      logic [IN_W-1:0]                   prev;
      tee_state_e                        state;
      logic [3:0]                        bit_cnt;
      logic [7:0]                        shift;
      logic [1:0]                        byte_no;
      logic                              is_id;
      logic                              is_write;
      logic                              store_ok;
      logic [PAGE_W-1:0]                 page;
      logic [OFF_W-1:0]                  off;
      logic                              pending;
      logic                              busy;
      logic [CNT_W-1:0]                  busy_cnt;
      logic [CNT_W-1:0]                  wr_cycles;
      logic [PAGE_BYTES-1:0]             valid;
      logic [PAGE_BYTES-1:0][7:0]        page_buf;
      logic [31:0]                       prdata;
      logic                              pready;
      logic                              pslverr;
      logic                              sda_oe_n;
      logic                              prog_start;
      logic                              prog_id;
      logic [PAGE_W-1:0]                 prog_page;
      logic                              standby;
   } tee_regs_s;

   localparam logic [CNT_W-1:0] WR_MAX = CNT_W'(WRITE_CYCLES);

   tee_regs_s r;
   tee_regs_s n;

   logic [IN_W-1:0] pins;
   logic [IN_W-1:0] agree;
   logic            scl;
   logic            sda;
   logic            scl_rise;
   logic            scl_fall;
   logic            start_c;
   logic            stop_c;
   logic [2:0]      strap;
   logic [3:0]      dev_type;
   logic            addr_match;
   logic            apb_setup;
   logic            apb_done;

   // read mux for the apb side; unmapped addresses flag an error
   function automatic logic [32:0] tee_read(input logic [PADDR_W-1:0] a,
                                            input tee_regs_s           s);
      logic [32:0] res;
      res = 33'h0_0000_0000;
      if (a[1:0] != 2'h0) begin
         res[32] = 1'b1;
      end else if (a[11:8] == BUF_SEL) begin
         res[7:0] = s.page_buf[a[7:2]];
      end else begin
         unique case (a)
            REG_CTRL: begin
               res[CNT_W-1:0] = s.wr_cycles;
            end
            REG_STATUS: begin
               res[ST_BUSY]    = s.busy;
               res[ST_STANDBY] = s.standby;
               res[ST_LOCKED]  = s.flt[IN_LOCK];
               res[ST_WP]      = s.flt[IN_WP];
               res[ST_PENDING] = s.pending;
               res[ST_PAGE_LO +: PAGE_W] = s.page;
            end
            REG_VALID_LO: begin
               res[31:0] = s.valid[31:0];
            end
            REG_VALID_HI: begin
               res[31:0] = s.valid[63:32];
            end
            default: begin
               res[32] = 1'b1;
            end
         endcase
      end
      return res;
   endfunction : tee_read

   assign pins = {chip_select_strap_bit2, chip_select_strap_bit1, chip_select_strap_bit0,
                  id_page_locked_in, write_protect_in, sda_in, scl_in};
   // a lane only moves once the second and third stages agree
   assign agree = ~(r.s2 ^ r.s3);

   assign scl      = r.flt[IN_SCL];
   assign sda      = r.flt[IN_SDA];
   assign scl_rise = scl & ~r.prev[IN_SCL];
   assign scl_fall = ~scl & r.prev[IN_SCL];
   // sda edges with scl held high are framing, never data
   assign start_c  = scl & r.prev[IN_SCL] & ~sda & r.prev[IN_SDA];
   assign stop_c   = scl & r.prev[IN_SCL] & sda & ~r.prev[IN_SDA];

   assign strap      = r.flt[IN_STRAP +: 3];
   assign dev_type   = r.shift[7:4];
   assign addr_match = ((dev_type == TYPE_ARRAY) || (dev_type == TYPE_ID))
                       && (r.shift[3:1] == strap);

   assign apb_setup = psel & penable & ~r.pready;
   assign apb_done  = psel & penable & r.pready;

   always_comb begin
      n = r;
      n.s1   = pins;
      n.s2   = r.s1;
      n.s3   = r.s2;
      n.flt  = (r.s3 & agree) | (r.flt & ~agree);
      n.prev = r.flt;
      n.prog_start = 1'b0;

      // self-timed programming interval
      if (r.busy) begin
         if (r.busy_cnt <= CNT_ONE) begin
            n.busy     = 1'b0;
            n.busy_cnt = '0;
         end else begin
            n.busy_cnt = r.busy_cnt - CNT_ONE;
         end
      end

      if (start_c) begin
         // restart from the address byte, whatever was in flight
         n.state    = TEE_RX;
         n.bit_cnt  = '0;
         n.byte_no  = BYTE_DEV;
         n.sda_oe_n = 1'b1;
      end else if (stop_c) begin
         n.state    = TEE_IDLE;
         n.sda_oe_n = 1'b1;
         if (r.is_write && r.pending && !r.busy) begin
            n.busy       = 1'b1;
            n.busy_cnt   = r.wr_cycles;
            n.pending    = 1'b0;
            n.prog_start = 1'b1;
            n.prog_id    = r.is_id;
            n.prog_page  = r.is_id ? '0 : r.page;
         end
      end else begin
         unique case (r.state)
            TEE_IDLE: begin
               // nothing on the bus matters until a start
               n.sda_oe_n = 1'b1;
            end
            TEE_RX: begin
               if (scl_rise && (r.bit_cnt < BITS_BYTE)) begin
                  n.shift   = {r.shift[6:0], sda};
                  n.bit_cnt = r.bit_cnt + 4'h1;
               end else if (scl_fall && (r.bit_cnt == BITS_BYTE)) begin
                  n.state = TEE_ACK;
                  unique case (r.byte_no)
                     BYTE_DEV: begin
                        n.is_id    = (dev_type == TYPE_ID);
                        n.is_write = (r.shift[0] != DIR_READ);
                        if (addr_match && !r.busy) begin
                           n.sda_oe_n = 1'b0;
                           if (r.shift[0] != DIR_READ) begin
                              n.valid   = '0;
                              n.pending = 1'b0;
                           end
                        end else begin
                           n.state = TEE_IDLE;
                        end
                        n.byte_no = BYTE_HI;
                     end
                     BYTE_HI: begin
                        n.page[PAGE_W-1:2] = r.shift[6:0];
                        n.store_ok = r.is_id ? ~r.shift[HI_A10_BIT]
                                             : ~r.flt[IN_WP];
                        n.sda_oe_n = 1'b0;
                        n.byte_no  = BYTE_LO;
                     end
                     BYTE_LO: begin
                        n.page[1:0] = r.shift[7:6];
                        n.off       = r.shift[OFF_W-1:0];
                        n.sda_oe_n  = 1'b0;
                        n.byte_no   = BYTE_DATA;
                     end
                     BYTE_DATA: begin
                        if (r.is_id && r.flt[IN_LOCK]) begin
                           n.state = TEE_IDLE;
                        end else begin
                           n.sda_oe_n = 1'b0;
                           if (r.store_ok && !(!r.is_id && r.flt[IN_WP])) begin
                              // later bytes for the same offset replace earlier ones
                              n.page_buf[r.off] = r.shift;
                              n.valid[r.off]    = 1'b1;
                              n.pending         = 1'b1;
                           end
                           n.off = r.off + 6'h01;
                        end
                     end
                  endcase
               end
            end
            TEE_ACK: begin
               // hold sda low through the ninth pulse, release on its fall
               if (scl_fall) begin
                  n.sda_oe_n = 1'b1;
                  n.bit_cnt  = '0;
                  n.state    = r.is_write ? TEE_RX : TEE_IDLE;
               end
            end
            default: begin
               n.state = TEE_IDLE;
            end
         endcase
      end

      n.standby = (n.state == TEE_IDLE) && !n.busy;

      // apb slave: one wait cycle, then pready
      n.pready = apb_setup;
      if (apb_setup) begin
         {n.pslverr, n.prdata} = tee_read(paddr, r);
      end else begin
         n.pslverr = 1'b0;
         n.prdata  = '0;
      end
      if (apb_done && pwrite && (paddr == REG_CTRL)) begin
         // clamp so the busy time never exceeds the nominal maximum
         if (pwdata[CNT_W-1:0] > WR_MAX) begin
            n.wr_cycles = WR_MAX;
         end else if (pwdata[CNT_W-1:0] == '0) begin
            n.wr_cycles = CNT_ONE;
         end else begin
            n.wr_cycles = pwdata[CNT_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r           <= '0;
         r.s1        <= IN_RST;
         r.s2        <= IN_RST;
         r.s3        <= IN_RST;
         r.flt       <= IN_RST;
         r.prev      <= IN_RST;
         r.state     <= TEE_IDLE;
         r.sda_oe_n  <= 1'b1;
         r.standby   <= 1'b1;
         r.wr_cycles <= WR_MAX;
      end else begin
         r <= n;
      end
   end

   assign prdata     = r.prdata;
   assign pready     = r.pready;
   assign pslverr    = r.pslverr;
   // open drain: only ever pulls low
   assign sda_out    = 1'b0;
   assign sda_oe_n   = r.sda_oe_n;
   assign prog_start = r.prog_start;
   assign prog_id    = r.prog_id;
   assign prog_page  = r.prog_page;
   assign standby    = r.standby;
endmodule : tee_slave
`default_nettype wire

// [tee_slave_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module tee_slave_assertions (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   input wire logic       prog_start,
   input wire logic       prog_id,
   input wire logic [8:0] prog_page,
   input wire logic       standby
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_second_a: assert property (psel && $rose(penable) |-> !pready ##1 pready ##1 !pready)
      else $error("pready not a pulse in second access cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr outside pready");
   drive_low_a: assert property (!sda_oe_n |-> !sda_out)
      else $error("data driven high");
   ack_edge_a: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data pin moved while clock high");
   ack_hold_a: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
      else $error("ack released early");
   busy_quiet_a: assert property (prog_start |=> (sda_oe_n && !standby) [*8])
      else $error("bus answered or standby while programming");
   prog_held_a: assert property ($changed(prog_page) || $changed(prog_id) |->
      prog_start || $past(prog_start))
      else $error("programming target moved without start");
   id_page_a: assert property (prog_id |-> prog_page == 9'h000)
      else $error("id page with nonzero page");
endmodule : tee_slave_assertions
`default_nettype wire
